// >>> temp_fmt_pkg.sv
package temp_fmt_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] CONFIG_OFS = 8'h00;
   localparam logic [7:0] RESOL_OFS = 8'h04;
   localparam logic [7:0] CONSEC_OFS = 8'h08;
   localparam logic [7:0] HYST_OFS = 8'h0C;
   localparam logic [7:0] LIMIT_BASE_OFS = 8'h10;
   localparam logic [7:0] LIMIT_LAST_OFS = 8'h24;
   localparam logic [7:0] LOCAL_HI_OFS = 8'h28;
   localparam logic [7:0] LOCAL_LO_OFS = 8'h2C;
   localparam logic [7:0] REMOTE_HI_OFS = 8'h30;
   localparam logic [7:0] REMOTE_LO_OFS = 8'h34;
   localparam logic [7:0] STATUS_OFS = 8'h38;
   localparam logic [7:0] PINS_OFS = 8'h3C;

   // ==========================================================
   // Field positions
   localparam int RANGE_BIT = 2;
   localparam int PIN6_FUNC_BIT = 5;
   localparam int MASK_BIT = 7;
   localparam int OPEN_BIT = 2;
   localparam logic [7:0] CONFIG_WMASK = 8'hA4;

   // ==========================================================
   // Limit array index: 0 local high, 1 local low, 2 remote high,
   // 3 remote low, 4 local critical, 5 remote critical
   localparam int LIMIT_COUNT = 6;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [1:0] RESOL_RST = 2'h3;
   localparam logic [1:0] CONSEC_RST = 2'h0;
   localparam logic [7:0] HYST_RST = 8'h0A;
   localparam logic [7:0] HIGH_LIMIT_RST = 8'h55;
   localparam logic [7:0] LOW_LIMIT_RST = 8'h00;
   localparam logic [7:0] CRIT_LIMIT_RST = 8'h55;

   // ==========================================================
   // Data format constants, temperatures in 1/16 degree steps
   localparam logic signed [13:0] EXT_OFFSET = 14'sh0400;
   localparam logic signed [13:0] STD_MAX = 14'sh07FF;
   localparam logic signed [13:0] EXT_MAX = 14'sh0FFF;
   localparam logic [7:0] STD_CLAMP_HI = 8'h7F;
   localparam logic [7:0] EXT_CLAMP_HI = 8'hFF;
   localparam logic [3:0] REMOTE_FRAC_MASK = 4'hF;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic valid;
      logic remote;
      logic fault;
      logic signed [12:0] temp;
   } conv_type;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
   } result_type;

endpackage

// >>> temp_result_format_and_alarm.sv
`timescale 1ns/10ps
module temp_result_format_and_alarm (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire temp_fmt_pkg::conv_type conv_in,
   input wire logic addr_read,
   input wire logic crit_alarm_n_in,
   output logic crit_alarm_n_out,
   output logic crit_alarm_n_oe_n,
   input wire logic second_crit_alarm_n_in,
   output logic second_crit_alarm_n_out,
   output logic second_crit_alarm_n_oe_n
);

   // ==========================================================
   // Result formatting
   function automatic temp_fmt_pkg::result_type fmt(
      input logic signed [12:0] t,
      input logic ext,
      input logic [3:0] fmask);
      logic signed [13:0] v;
      temp_fmt_pkg::result_type r;
      v = {t[12], t} + (ext ? temp_fmt_pkg::EXT_OFFSET : 14'sh0000);
      if (v < 14'sh0000) begin
         r = 16'h0000;
      end else if (!ext && v > temp_fmt_pkg::STD_MAX) begin
         r = {temp_fmt_pkg::STD_CLAMP_HI, 8'h00};
      end else if (ext && v > temp_fmt_pkg::EXT_MAX) begin
         r = {temp_fmt_pkg::EXT_CLAMP_HI, 8'h00};
      end else begin
         r.hi = v[11:4];
         r.lo = {v[3:0] & fmask, 4'h0};
      end
      return r;
   endfunction

   // Hysteresis alarm: sets beyond limits, releases inside by hyst
   function automatic logic hyst_alarm(
      input logic cur,
      input logic [7:0] code,
      input logic [7:0] hi,
      input logic [7:0] lo,
      input logic use_lo,
      input logic [7:0] hy);
      logic set;
      logic rel;
      set = (code > hi) || (use_lo && code < lo);
      rel = ({1'b0, code} + {1'b0, hy} <= {1'b0, hi}) &&
         (!use_lo || {1'b0, code} >= {1'b0, lo} + {1'b0, hy});
      return set ? 1'b1 : (rel ? 1'b0 : cur);
   endfunction

   // ==========================================================
   // Registers and state
   logic [7:0] cfg;
   logic [1:0] resol;
   logic [1:0] consec;
   logic [7:0] hyst;
   logic [7:0] limit [temp_fmt_pkg::LIMIT_COUNT];
   temp_fmt_pkg::result_type result [2];
   logic [1:0] crit_state;
   logic [1:0] crit2_state;
   logic [1:0] high_flag;
   logic [1:0] low_flag;
   logic open_flag;
   logic [1:0] cur_viol;
   logic [1:0] viol_cnt [2];
   logic alert_latch;
   logic [1:0] pin_meta;
   logic [1:0] pin_sync;

   // ==========================================================
   // APB decode
   wire setup = psel && !penable;
   wire access = psel && penable && pready;
   wire wr = access && pwrite;
   wire rd = access && !pwrite;
   wire is_limit = paddr >= temp_fmt_pkg::LIMIT_BASE_OFS &&
      paddr <= temp_fmt_pkg::LIMIT_LAST_OFS && paddr[1:0] == 2'h0;
   wire [7:0] lim_ofs = paddr - temp_fmt_pkg::LIMIT_BASE_OFS;
   wire [2:0] lim_idx = lim_ofs[4:2];
   wire mapped = is_limit || (paddr[1:0] == 2'h0 && paddr <=
      temp_fmt_pkg::PINS_OFS);
   wire [3:0] local_mask = {1'b1, resol != 2'h0, resol[1],
      resol == 2'h3};
   wire [7:0] status = {1'b0, high_flag[0], low_flag[0], high_flag[1],
      low_flag[1], open_flag, crit_state[1], crit_state[0]};
   wire ext_range = cfg[temp_fmt_pkg::RANGE_BIT];
   wire second_is_crit = cfg[temp_fmt_pkg::PIN6_FUNC_BIT];
   wire warn_masked = cfg[temp_fmt_pkg::MASK_BIT];
   wire status_rd = rd && paddr == temp_fmt_pkg::STATUS_OFS;
   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      if (is_limit) begin
         rd_byte = limit[lim_idx];
      end else begin
         unique case (paddr)
            temp_fmt_pkg::CONFIG_OFS: rd_byte = cfg;
            temp_fmt_pkg::RESOL_OFS: rd_byte = {6'h00, resol};
            temp_fmt_pkg::CONSEC_OFS: rd_byte = {6'h00, consec};
            temp_fmt_pkg::HYST_OFS: rd_byte = hyst;
            temp_fmt_pkg::LOCAL_HI_OFS: rd_byte = result[0].hi;
            temp_fmt_pkg::LOCAL_LO_OFS: rd_byte = result[0].lo;
            temp_fmt_pkg::REMOTE_HI_OFS: rd_byte = result[1].hi;
            temp_fmt_pkg::REMOTE_LO_OFS: rd_byte = result[1].lo;
            temp_fmt_pkg::STATUS_OFS: rd_byte = status;
            temp_fmt_pkg::PINS_OFS: rd_byte = {6'h00, pin_sync};
            default: rd_byte = 8'h00;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !mapped;
         if (setup) begin
            prdata <= {24'h00_0000, rd_byte};
         end
      end
   end

   // ==========================================================
   // Configuration and limit registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= temp_fmt_pkg::CONFIG_RST;
         resol <= temp_fmt_pkg::RESOL_RST;
         consec <= temp_fmt_pkg::CONSEC_RST;
         hyst <= temp_fmt_pkg::HYST_RST;
      end else if (wr) begin
         if (paddr == temp_fmt_pkg::CONFIG_OFS) begin
            cfg <= pwdata[7:0] & temp_fmt_pkg::CONFIG_WMASK;
         end
         if (paddr == temp_fmt_pkg::RESOL_OFS) begin
            resol <= pwdata[1:0];
         end
         if (paddr == temp_fmt_pkg::CONSEC_OFS) begin
            consec <= pwdata[1:0];
         end
         if (paddr == temp_fmt_pkg::HYST_OFS) begin
            hyst <= pwdata[7:0];
         end
      end
   end

   // Limits change only by software writes, never by range changes
   genvar li;
   generate
      for (li = 0; li < temp_fmt_pkg::LIMIT_COUNT; li++) begin : g_lim
         localparam logic [7:0] RST = (li >= 4) ?
            temp_fmt_pkg::CRIT_LIMIT_RST : (li % 2 == 0) ?
            temp_fmt_pkg::HIGH_LIMIT_RST : temp_fmt_pkg::LOW_LIMIT_RST;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               limit[li] <= RST;
            end else if (wr && is_limit && lim_idx == 3'(li)) begin
               limit[li] <= pwdata[7:0];
            end
         end
      end
   endgenerate

   // ==========================================================
   // Per-channel results, alarms and flags (0 local, 1 remote)
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_ch
         wire take = conv_in.valid && conv_in.remote == 1'(ch);
         wire fault = (ch == 1) && conv_in.fault;
         wire [3:0] fmask = (ch == 1) ? temp_fmt_pkg::REMOTE_FRAC_MASK :
            local_mask;
         wire temp_fmt_pkg::result_type fresh = fmt(conv_in.temp,
            ext_range, fmask);
         wire [7:0] code = fault ? result[ch].hi : fresh.hi;
         wire [7:0] hi_lim = limit[2 * ch];
         wire [7:0] lo_lim = limit[2 * ch + 1];
         wire over = code > hi_lim;
         wire under = code < lo_lim;
         wire viol = over || under;
         wire count_met = viol_cnt[ch] >= consec;

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               result[ch] <= 16'h0000;
               crit_state[ch] <= 1'b0;
               crit2_state[ch] <= 1'b0;
               cur_viol[ch] <= 1'b0;
               viol_cnt[ch] <= 2'h0;
            end else if (take) begin
               if (!fault) begin
                  result[ch] <= fresh;
               end
               crit_state[ch] <= hyst_alarm(crit_state[ch], code,
                  limit[4 + ch], 8'h00, 1'b0, hyst);
               crit2_state[ch] <= hyst_alarm(crit2_state[ch], code,
                  hi_lim, lo_lim, 1'b1, hyst);
               cur_viol[ch] <= viol || fault;
               if (!viol) begin
                  viol_cnt[ch] <= 2'h0;
               end else if (!count_met) begin
                  viol_cnt[ch] <= viol_cnt[ch] + 2'h1;
               end
            end
         end

         // Hardware set wins over clear on status read
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               high_flag[ch] <= 1'b0;
               low_flag[ch] <= 1'b0;
            end else begin
               high_flag[ch] <= (take && viol && count_met && over) ||
                  (high_flag[ch] && !(status_rd && prdata[6 - 2 * ch]));
               low_flag[ch] <= (take && viol && count_met && under) ||
                  (low_flag[ch] && !(status_rd && prdata[5 - 2 * ch]));
            end
         end

         crit_set_a: assert property (@(posedge pclk)
            disable iff (!presetn)
            take && code > limit[4 + ch] |=> crit_state[ch])
            else $error("critical state not set");
         early_warn_a: assert property (@(posedge pclk)
            disable iff (!presetn)
            take && viol_cnt[ch] < consec && !high_flag[ch]
            |=> !high_flag[ch])
            else $error("warning flag set too early");
      end
   endgenerate

   wire open_set = conv_in.valid && conv_in.remote && conv_in.fault;
   wire [1:0] flag_any = high_flag | low_flag;
   wire warn_set = |flag_any || open_set;
   wire alert_clear = addr_read && !(|high_flag) && !(|low_flag) &&
      !open_flag && !(|cur_viol);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         open_flag <= 1'b0;
         alert_latch <= 1'b0;
      end else begin
         open_flag <= open_set ||
            (open_flag && !(status_rd && prdata[temp_fmt_pkg::OPEN_BIT]));
         alert_latch <= warn_set || (alert_latch && !alert_clear);
      end
   end

   // ==========================================================
   // Alarm pins: open-drain, enable low pulls the line low
   wire second_drive = second_is_crit ? |crit2_state :
      (alert_latch && !warn_masked);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crit_alarm_n_out <= 1'b0;
         second_crit_alarm_n_out <= 1'b0;
         crit_alarm_n_oe_n <= 1'b1;
         second_crit_alarm_n_oe_n <= 1'b1;
         pin_meta <= 2'h0;
         pin_sync <= 2'h0;
      end else begin
         crit_alarm_n_out <= 1'b0;
         second_crit_alarm_n_out <= 1'b0;
         crit_alarm_n_oe_n <= !(|crit_state);
         second_crit_alarm_n_oe_n <= !second_drive;
         pin_meta <= {second_crit_alarm_n_in, crit_alarm_n_in};
         pin_sync <= pin_meta;
      end
   end

   // ==========================================================
   // Checks
   crit_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
      |crit_state |=> !crit_alarm_n_oe_n)
      else $error("critical alarm not driven");
   std_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_in.valid && !conv_in.remote && !ext_range && conv_in.temp < 0
      |=> result[0] == 16'h0000)
      else $error("negative standard result not clamped");
   ext_offset_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_in.valid && !conv_in.remote && ext_range && conv_in.temp == 0
      |=> result[0].hi == 8'h40)
      else $error("extended offset missing");
   result_hold_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !conv_in.valid |=> $stable(result[0]) && $stable(result[1]))
      else $error("result changed without conversion");
   remote_frac_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      conv_in.valid && conv_in.remote && !conv_in.fault &&
      conv_in.temp >= 0 && !ext_range && conv_in.temp <= 13'sh07FF
      |=> result[1].lo == {$past(conv_in.temp[3:0]), 4'h0})
      else $error("remote fraction wrong");
   local_frac_a: assert property (@(posedge pclk) disable iff (!presetn)
      conv_in.valid && !conv_in.remote && resol == 2'h0
      |=> result[0].lo[6:0] == 7'h00)
      else $error("local fraction not masked");
   fault_keep_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      open_set |=> $stable(result[1]) && open_flag)
      else $error("fault handling wrong");
   warn_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
      warn_masked && !second_is_crit |=> second_crit_alarm_n_oe_n)
      else $error("masked warning drove pin");
   warn_latch_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      alert_latch && !addr_read |=> alert_latch)
      else $error("warning released without address read");
   apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup |=> pready)
      else $error("access phase not ready");
   apb_error_a: assert property (@(posedge pclk) disable iff (!presetn)
      setup && !mapped |=> pslverr)
      else $error("unmapped address not refused");
   apb_once_a: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready)
      else $error("ready stood too long");
   limit_keep_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !(wr && is_limit) |=> $stable(limit[0]) && $stable(limit[5]))
      else $error("limit changed without write");
   crit_free_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !(|crit_state) |=> crit_alarm_n_oe_n)
      else $error("critical alarm not released");
   second_crit_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      second_is_crit && |crit2_state |=> !second_crit_alarm_n_oe_n)
      else $error("second critical alarm not driven");
   warn_pin_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      !second_is_crit && !warn_masked && alert_latch
      |=> !second_crit_alarm_n_oe_n)
      else $error("warning alarm not driven");
   open_warn_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      open_set |=> alert_latch)
      else $error("open circuit did not warn");
   warn_hold_a: assert property (@(posedge pclk)
      disable iff (!presetn)
      alert_latch && (|high_flag || |low_flag || open_flag) |=> alert_latch)
      else $error("warning released while flags set");

endmodule // temp_result_format_and_alarm

// >>> host_model.sv
`timescale 1ns/10ps
// ====
// Host side of the alarm lines
module host_model (
   input wire logic pclk,
   input wire logic crit_out,
   input wire logic crit_oe_n,
   input wire logic sec_out,
   input wire logic sec_oe_n,
   output logic crit_line,
   output logic sec_line,
   output logic addr_read
);
   // Pull-ups hold a released line high
   assign crit_line = crit_oe_n ? 1'b1 : crit_out;
   assign sec_line = sec_oe_n ? 1'b1 : sec_out;
   initial addr_read = 1'b0;
   // Address read that lets the warning release
   task automatic read_address();
      @(posedge pclk);
      addr_read <= 1'b1;
      @(posedge pclk);
      addr_read <= 1'b0;
   endtask
endmodule // host_model

// >>> temp_result_format_and_alarm_tb_top.sv
`timescale 1ns/10ps
module temp_result_format_and_alarm_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, err, addr_read, crit_line, sec_line;
   logic crit_out, crit_oe_n, sec_out, sec_oe_n;
   temp_fmt_pkg::conv_type conv_in = '0;
   int fails = 0;
   int compares = 0;
   int cycles = 0;
   always #12.5 pclk = ~pclk;
   temp_result_format_and_alarm i_temp_result_format_and_alarm (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_in(conv_in),
      .addr_read(addr_read), .crit_alarm_n_in(crit_line),
      .crit_alarm_n_out(crit_out), .crit_alarm_n_oe_n(crit_oe_n),
      .second_crit_alarm_n_in(sec_line),
      .second_crit_alarm_n_out(sec_out),
      .second_crit_alarm_n_oe_n(sec_oe_n));
   host_model i_host_model (.pclk(pclk), .crit_out(crit_out),
      .crit_oe_n(crit_oe_n), .sec_out(sec_out), .sec_oe_n(sec_oe_n),
      .crit_line(crit_line), .sec_line(sec_line), .addr_read(addr_read));
   // ====
   // Bus and conversion tasks
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_pin(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk_reg(rd, {24'h0, e});
   endtask
   task automatic conv(input logic r, input logic f,
      input logic signed [12:0] t);
      @(posedge pclk);
      conv_in <= '{valid: 1'b1, remote: r, fault: f, temp: t};
      @(posedge pclk);
      conv_in.valid <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic summarize();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         summarize();
      end
   end
   // ====
   // Test sequence
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rchk(temp_fmt_pkg::HYST_OFS, 8'h0A);
      rchk(temp_fmt_pkg::CONFIG_OFS, 8'h00);
      rchk(temp_fmt_pkg::RESOL_OFS, 8'h03);
      rchk(temp_fmt_pkg::LIMIT_BASE_OFS, 8'h55);
      apb(1'b0, 8'h40, 8'h00);
      chk_pin(err, 1'b1);
      apb(1'b1, temp_fmt_pkg::LIMIT_BASE_OFS, 8'hFF);
      apb(1'b1, 8'h20, 8'hFF);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, temp_fmt_pkg::RESOL_OFS, i[7:0]);
         conv(1'b0, 1'b0, 13'sd411);
         rchk(temp_fmt_pkg::LOCAL_HI_OFS, 8'h19);
         rchk(temp_fmt_pkg::LOCAL_LO_OFS,
            {4'hB & (4'hF << (3 - i)), 4'h0});
      end
      apb(1'b1, temp_fmt_pkg::RESOL_OFS, 8'h00);
      conv(1'b1, 1'b0, 13'sd393);
      rchk(temp_fmt_pkg::REMOTE_HI_OFS, 8'h18);
      rchk(temp_fmt_pkg::REMOTE_LO_OFS, 8'h90);
      conv(1'b0, 1'b0, -13'sd80);
      rchk(temp_fmt_pkg::LOCAL_HI_OFS, 8'h00);
      conv(1'b0, 1'b0, 13'sd2400);
      rchk(temp_fmt_pkg::LOCAL_HI_OFS, 8'h7F);
      // ====
      // Extended range
      apb(1'b1, temp_fmt_pkg::CONFIG_OFS, 8'h04);
      rchk(temp_fmt_pkg::LOCAL_HI_OFS, 8'h7F);
      rchk(temp_fmt_pkg::LIMIT_BASE_OFS, 8'hFF);
      conv(1'b0, 1'b0, -13'sd392);
      rchk(temp_fmt_pkg::LOCAL_HI_OFS, 8'h27);
      rchk(temp_fmt_pkg::LOCAL_LO_OFS, 8'h80);
      conv(1'b0, 1'b0, 13'sd3056);
      rchk(temp_fmt_pkg::LOCAL_HI_OFS, 8'hFF);
      conv(1'b0, 1'b0, -13'sd1040);
      rchk(temp_fmt_pkg::LOCAL_HI_OFS, 8'h00);
      // ====
      // Critical alarm
      apb(1'b1, temp_fmt_pkg::CONFIG_OFS, 8'h00);
      apb(1'b1, 8'h20, 8'h55);
      conv(1'b0, 1'b0, 13'sd1440);
      chk_pin(crit_line, 1'b0);
      apb(1'b1, temp_fmt_pkg::CONFIG_OFS, 8'h80);
      conv(1'b0, 1'b0, 13'sd1440);
      chk_pin(crit_line, 1'b0);
      apb(1'b1, temp_fmt_pkg::CONFIG_OFS, 8'h00);
      conv(1'b0, 1'b0, 13'sd1280);
      chk_pin(crit_line, 1'b0);
      conv(1'b0, 1'b0, 13'sd1200);
      chk_pin(crit_line, 1'b1);
      // ====
      // Warning alarm
      apb(1'b1, 8'h20, 8'hFF);
      apb(1'b1, temp_fmt_pkg::LIMIT_BASE_OFS, 8'h3C);
      apb(1'b1, temp_fmt_pkg::CONSEC_OFS, 8'h01);
      conv(1'b0, 1'b0, 13'sd992);
      chk_pin(sec_line, 1'b1);
      conv(1'b0, 1'b0, 13'sd992);
      chk_pin(sec_line, 1'b0);
      conv(1'b0, 1'b0, 13'sd640);
      chk_pin(sec_line, 1'b0);
      rchk(temp_fmt_pkg::STATUS_OFS, 8'h40);
      i_host_model.read_address();
      repeat (3) @(posedge pclk);
      chk_pin(sec_line, 1'b1);
      conv(1'b1, 1'b1, 13'sd800);
      rchk(temp_fmt_pkg::REMOTE_HI_OFS, 8'h18);
      chk_pin(sec_line, 1'b0);
      rchk(temp_fmt_pkg::STATUS_OFS, 8'h04);
      apb(1'b1, temp_fmt_pkg::CONFIG_OFS, 8'h80);
      repeat (2) @(posedge pclk);
      chk_pin(sec_line, 1'b1);
      // ====
      // Second critical mode
      apb(1'b1, temp_fmt_pkg::CONFIG_OFS, 8'h20);
      rchk(temp_fmt_pkg::CONFIG_OFS, 8'h20);
      conv(1'b0, 1'b0, 13'sd992);
      chk_pin(sec_line, 1'b0);
      conv(1'b0, 1'b0, 13'sd880);
      chk_pin(sec_line, 1'b0);
      conv(1'b0, 1'b0, 13'sd800);
      chk_pin(sec_line, 1'b1);
      rchk(temp_fmt_pkg::PINS_OFS, 8'h03);
      summarize();
   end
endmodule // temp_result_format_and_alarm_tb_top
